/* ftpwm_params.svh */
// timing counts, register offsets and reset values of the fan tray block
`ifndef FTPWM_PARAMS_SVH
`define FTPWM_PARAMS_SVH
`define FTPWM_CLK_HZ 200000000
`define FTPWM_TACH_WIN_MS 200
`define FTPWM_TACH_WIN_CYC ((`FTPWM_CLK_HZ / 1000) * `FTPWM_TACH_WIN_MS)
`define FTPWM_RAMP_STEP_MS 500
`define FTPWM_RAMP_STEP_CYC ((`FTPWM_CLK_HZ / 1000) * `FTPWM_RAMP_STEP_MS)
`define FTPWM_PWM_SLOT_CYC 7'h7F
`define FTPWM_PWM_LAST_PHASE 6'h3E
`define FTPWM_DUTY_MAX 6'h3F
`define FTPWM_DUTY_RST 6'h20
`define FTPWM_TACH_MAX 8'hFF
`define FTPWM_FLD_STRIDE 8
`define FTPWM_OFS_TARGET 8'h00
`define FTPWM_OFS_APPLIED 8'h04
`define FTPWM_OFS_TACH 8'h08
`define FTPWM_OFS_STATUS 8'h0C
`define FTPWM_OFS_IRQ_STAT 8'h10
`define FTPWM_OFS_IRQ_CLR 8'h14
`define FTPWM_OFS_IRQ_EN 8'h18
`define FTPWM_IRQ_EN_RST 9'h000
`endif

/* ftpwm_pkg.sv */
// shared types of the fan tray pwm and tachometer block
package ftpwm_pkg;
  typedef enum logic [1:0] {TRAY_ABSENT, TRAY_RAMP, TRAY_RUN} ftpwm_mode_e;
  typedef struct packed {
    logic win;
    logic [3:0] rem;
    logic [3:0] ins;
  } ftpwm_irq_s;
  typedef logic [5:0] ftpwm_duty_t;
  typedef logic [7:0] ftpwm_tach_t;
endpackage

/* ftpwm_pwm_chan.sv */
// one pwm channel with 63 duty slots per period
`timescale 1ns/1ps
`include "ftpwm_params.svh"
module ftpwm_pwm_chan import ftpwm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire ftpwm_duty_t duty,
  output logic pwm
);
  logic [6:0] slot_cnt;
  logic [5:0] phase;

  // slot divider and phase 0..62
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_cnt <= 7'h00;
      phase <= 6'h00;
    end else if (slot_cnt == `FTPWM_PWM_SLOT_CYC - 7'h01) begin
      slot_cnt <= 7'h00;
      phase <= (phase == `FTPWM_PWM_LAST_PHASE) ? 6'h00 : phase + 6'h01;
    end else begin
      slot_cnt <= slot_cnt + 7'h01;
    end
  end

  // high for duty of 63 slots
  // code 63 never falls, code 0 never rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm <= 1'b0;
    end else begin
      pwm <= (phase < duty);
    end
  end

  // full and zero codes never toggle
  a_pwm_full_high: assert property (
    @(posedge pclk) disable iff (!presetn)
    duty == `FTPWM_DUTY_MAX |=> pwm)
    else $error("full duty code did not hold pwm high");
  a_pwm_zero_low: assert property (
    @(posedge pclk) disable iff (!presetn)
    duty == 6'h00 |=> !pwm)
    else $error("zero duty code did not hold pwm low");
  // edges at period start and code
  // a code change moves the edge mid-period, so only a code held over the
  // two cycles that made the edge is checked
  a_pwm_rise_start: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(pwm) && $past(duty) == $past(duty, 2) |-> $past(phase) == 6'h00)
    else $error("pwm rose away from period start");
  a_pwm_fall_point: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(pwm) && $past(duty) == $past(duty, 2)
    |-> $past(phase) == $past(duty))
    else $error("pwm fell at the wrong slot");
endmodule // ftpwm_pwm_chan

/* ftpwm_tach_chan.sv */
// one tachometer input: synchroniser, edge count, window latch
`timescale 1ns/1ps
`include "ftpwm_params.svh"
module ftpwm_tach_chan import ftpwm_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tach_pin,
  input wire logic win_tick,
  output ftpwm_tach_t count
);
  logic sync1;
  logic sync2;
  logic last;
  logic edge_seen;
  ftpwm_tach_t acc;

  // two-stage synchroniser, third stage only for edge detect
  // reset to the pulled-up idle level so release shows no false edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      last <= 1'b1;
    end else begin
      sync1 <= tach_pin;
      sync2 <= sync1;
      last <= sync2;
    end
  end
  assign edge_seen = sync2 & ~last;

  // count rising edges, latch at window end
  // saturate so fast fans never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 8'h00;
      count <= 8'h00;
    end else if (win_tick) begin
      acc <= 8'h00;
      count <= (edge_seen && acc != `FTPWM_TACH_MAX) ? acc + 8'h01 : acc;
    end else if (edge_seen && acc != `FTPWM_TACH_MAX) begin
      acc <= acc + 8'h01;
    end
  end

  // latch and restart at window end
  a_tach_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    win_tick && !edge_seen |=> count == $past(acc) && acc == 8'h00)
    else $error("window count not latched or not restarted");
  a_tach_no_wrap: assert property (
    @(posedge pclk) disable iff (!presetn)
    acc == `FTPWM_TACH_MAX && !win_tick |=> acc == `FTPWM_TACH_MAX)
    else $error("tachometer count wrapped");
endmodule // ftpwm_tach_chan

/* ftpwm_top.sv */
// four-tray fan pwm and tachometer controller with apb registers
`timescale 1ns/1ps
`include "ftpwm_params.svh"
// Summary of operation
// - Each tray holds a 6-bit duty code and its pwm is high code/63.
// - Code 63 keeps the pwm high and code 0 keeps it low.
// - Tach pulses are counted per 200 ms window, last count readable.
// - The count holds up to 255 pulses per window without overflow.
// - A tray becoming present has its pwm taken over by a soft ramp.
// - Every tray target duty is 50% after reset.
// - The ramp climbs from 0% towards the 50% target over 16 s.
// - During the ramp the duty rises one level every 500 ms.
// - One controller serves four trays, upper or lower group.
// - Presence and tach speed are monitored besides pwm drive.
// - The management controller reaches control and status by bus.
module ftpwm_top import ftpwm_pkg::*; #(
  parameter int TACH_WIN_CYC = `FTPWM_TACH_WIN_CYC,
  parameter int RAMP_STEP_CYC = `FTPWM_RAMP_STEP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] tray_present,
  input wire logic [3:0] tach_in,
  output logic [3:0] pwm_out,
  output logic irq
);
  logic [3:0] pres1;
  logic [3:0] present_s;
  logic [3:0] pres_last;
  logic [26:0] win_cnt;
  logic win_tick;
  ftpwm_duty_t target [4];
  ftpwm_duty_t applied [4];
  ftpwm_mode_e mode [4];
  logic [26:0] step_cnt [4];
  ftpwm_tach_t tach_cnt [4];
  logic [3:0] ramping;
  ftpwm_irq_s irq_stat;
  ftpwm_irq_s irq_en;
  ftpwm_irq_s irq_evt;
  logic wr_done;
  logic [31:0] next_rdata;
  logic next_err;
  logic target_written;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // presence pins: two flops, then a third for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pres1 <= 4'h0;
      present_s <= 4'h0;
      pres_last <= 4'h0;
    end else begin
      pres1 <= tray_present;
      present_s <= pres1;
      pres_last <= present_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= 27'h0000000;
      win_tick <= 1'b0;
    end else if (win_cnt == 27'(TACH_WIN_CYC - 1)) begin
      win_cnt <= 27'h0000000;
      win_tick <= 1'b1;
    end else begin
      win_cnt <= win_cnt + 27'h0000001;
      win_tick <= 1'b0;
    end
  end

  // completed apb write, taken at the access edge only
  assign wr_done = psel & penable & pwrite & pready;

  for (genvar i = 0; i < 4; i++) begin : g_tray
    // written code becomes the new target
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        target[i] <= `FTPWM_DUTY_RST;
      end else if (wr_done && paddr == `FTPWM_OFS_TARGET) begin
        target[i] <= pwdata[i*`FTPWM_FLD_STRIDE +: 6];
      end
    end

    // removal forces duty zero, ramp restarts
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mode[i] <= TRAY_ABSENT;
        applied[i] <= 6'h00;
        step_cnt[i] <= 27'h0000000;
      end else if (!present_s[i]) begin
        mode[i] <= TRAY_ABSENT;
        applied[i] <= 6'h00;
        step_cnt[i] <= 27'h0000000;
      end else begin
        unique case (mode[i])
          TRAY_ABSENT: begin
            mode[i] <= TRAY_RAMP;
            applied[i] <= 6'h00;
            step_cnt[i] <= 27'h0000000;
          end
          TRAY_RAMP: begin
            // stop at target, even if lowered meanwhile
            if (applied[i] >= target[i]) begin
              applied[i] <= target[i];
              mode[i] <= TRAY_RUN;
            // one level per 500 ms step
            end else if (step_cnt[i] == 27'(RAMP_STEP_CYC - 1)) begin
              step_cnt[i] <= 27'h0000000;
              applied[i] <= applied[i] + 6'h01;
            end else begin
              step_cnt[i] <= step_cnt[i] + 27'h0000001;
            end
          end
          TRAY_RUN: begin
            // after the ramp writes apply at once
            applied[i] <= target[i];
          end
        endcase
      end
    end
    assign ramping[i] = (mode[i] == TRAY_RAMP);

    // duty code drives the tray pwm
    ftpwm_pwm_chan u_pwm (
      .pclk(pclk),
      .presetn(presetn),
      .duty(applied[i]),
      .pwm(pwm_out[i])
    );

    ftpwm_tach_chan u_tach (
      .pclk(pclk),
      .presetn(presetn),
      .tach_pin(tach_in[i]),
      .win_tick(win_tick),
      .count(tach_cnt[i])
    );

    a_ramp_start: assert property (
      $rose(present_s[i]) |=> mode[i] == TRAY_RAMP && applied[i] == 6'h00)
      else $error("insertion did not start ramp from zero");
    a_ramp_step: assert property (
      present_s[i] && mode[i] == TRAY_RAMP && applied[i] < target[i] &&
      step_cnt[i] == 27'(RAMP_STEP_CYC - 1)
      |=> applied[i] == $past(applied[i]) + 6'h01)
      else $error("ramp step did not add one level");
    a_ramp_hold: assert property (
      present_s[i] && mode[i] == TRAY_RAMP && applied[i] < target[i] &&
      step_cnt[i] != 27'(RAMP_STEP_CYC - 1) |=> $stable(applied[i]))
      else $error("ramp moved between steps");
    a_ramp_end: assert property (
      present_s[i] && mode[i] == TRAY_RAMP && applied[i] >= target[i]
      |=> mode[i] == TRAY_RUN && applied[i] == $past(target[i]))
      else $error("ramp did not settle on the target");
    a_absent_off: assert property (
      !present_s[i] |=> applied[i] == 6'h00 ##1 !pwm_out[i])
      else $error("absent tray pwm not forced low");
    a_absent_mode: assert property (
      !present_s[i] |=> mode[i] == TRAY_ABSENT && step_cnt[i] == 27'h0000000)
      else $error("absent tray kept its ramp state");
    a_target_write: assert property (
      wr_done && paddr == `FTPWM_OFS_TARGET
      |=> target[i] == $past(pwdata[i*`FTPWM_FLD_STRIDE +: 6]))
      else $error("duty write not stored as target");
    a_target_keep: assert property (
      !(wr_done && paddr == `FTPWM_OFS_TARGET) |=> $stable(target[i]))
      else $error("target changed without a write");
    a_run_follow: assert property (
      present_s[i] && mode[i] == TRAY_RUN
      |=> applied[i] == $past(target[i]))
      else $error("running tray did not follow its target");
    a_reset_target: assert property (
      !target_written |-> target[i] == `FTPWM_DUTY_RST)
      else $error("target not at half duty before any write");
    // main tray scenarios
    c_ramp_done: cover property (
      mode[i] == TRAY_RAMP ##1 mode[i] == TRAY_RUN);
    c_tray_removed: cover property ($fell(present_s[i]));
  end

  // helper: any target write seen since reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_written <= 1'b0;
    end else if (wr_done && paddr == `FTPWM_OFS_TARGET) begin
      target_written <= 1'b1;
    end
  end

  // interrupt events of this cycle
  assign irq_evt.ins = present_s & ~pres_last;
  assign irq_evt.rem = ~present_s & pres_last;
  assign irq_evt.win = win_tick;

  // sticky status, set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else if (wr_done && paddr == `FTPWM_OFS_IRQ_CLR) begin
      irq_stat <= (irq_stat & ~pwdata[8:0]) | irq_evt;
    end else begin
      irq_stat <= irq_stat | irq_evt;
    end
  end

  // interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= `FTPWM_IRQ_EN_RST;
    end else if (wr_done && paddr == `FTPWM_OFS_IRQ_EN) begin
      irq_en <= pwdata[8:0];
    end
  end

  // registered level output, one cycle behind the status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_en);
    end
  end

  // read decode, sampled in the setup cycle
  // presence, ramp state and tach counts are readable
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    unique case (paddr)
      `FTPWM_OFS_TARGET: next_rdata = {2'h0, target[3], 2'h0, target[2],
                                       2'h0, target[1], 2'h0, target[0]};
      `FTPWM_OFS_APPLIED: next_rdata = {2'h0, applied[3], 2'h0, applied[2],
                                        2'h0, applied[1], 2'h0, applied[0]};
      `FTPWM_OFS_TACH: next_rdata = {tach_cnt[3], tach_cnt[2],
                                     tach_cnt[1], tach_cnt[0]};
      `FTPWM_OFS_STATUS: next_rdata = {24'h000000, ramping, present_s};
      `FTPWM_OFS_IRQ_STAT: next_rdata = {23'h000000, irq_stat};
      `FTPWM_OFS_IRQ_CLR: next_rdata = 32'h00000000;
      `FTPWM_OFS_IRQ_EN: next_rdata = {23'h000000, irq_en};
      default: next_err = 1'b1;
    endcase
  end

  // apb slave, answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h00000000 : next_rdata;
      pready <= 1'b1;
      pslverr <= next_err;
    end else if (pready) begin
      // drop the answer so a stray penable waits for a setup
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  a_apb_zero_wait: assert property (
    psel && !penable |=> pready)
    else $error("apb access phase did not complete at once");
  a_apb_release: assert property (
    pready && !(psel && !penable) |=> !pready)
    else $error("pready stayed high without a new access");
  // read data of the setup cycle
  a_apb_rdata: assert property (
    psel && !penable && !pwrite |=> prdata == $past(next_rdata))
    else $error("read data differs from the decoded register");
  a_apb_error: assert property (
    psel && !penable |=> pslverr == $past(next_err))
    else $error("error response does not match the decode");
  a_apb_idle: assert property (
    !pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("read data or error shown outside an answer");
  a_win_tick: assert property (
    win_tick |-> win_cnt == 27'h0000000 ##1 !win_tick)
    else $error("window tick out of step with its counter");
  a_stat_sticky: assert property (
    !(wr_done && paddr == `FTPWM_OFS_IRQ_CLR)
    |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit lost without a clear");
  a_stat_set: assert property (
    1'b1 |=> (irq_stat & $past(irq_evt)) == $past(irq_evt))
    else $error("event did not set its status bit");
  a_stat_clear: assert property (
    wr_done && paddr == `FTPWM_OFS_IRQ_CLR
    |=> (irq_stat & $past(pwdata[8:0] & ~irq_evt)) == 9'h000)
    else $error("status clear left a bit set");
  a_en_write: assert property (
    wr_done && paddr == `FTPWM_OFS_IRQ_EN |=> irq_en == $past(pwdata[8:0]))
    else $error("interrupt enable write not stored");
  a_irq_level: assert property (
    1'b1 |=> irq == $past(|(irq_stat & irq_en)))
    else $error("irq does not follow enabled status");
  a_irq_quiet: assert property (
    irq_en == 9'h000 |=> !irq)
    else $error("irq raised with every source disabled");
  // main bus and interrupt scenarios
  c_win_done: cover property (win_tick);
  c_irq_raised: cover property ($rose(irq));
endmodule // ftpwm_top

/* ftpwm_fan_model.sv */
// behavioural model of four fan trays: presence and tach pulses
`timescale 1ns/1ps
module ftpwm_fan_model (
  input wire logic pclk,
  input wire logic [3:0] plug,
  output logic [3:0] tray_present,
  output logic [3:0] tach
);
  // tach half periods in clocks; each divides the window exactly
  localparam int HALF [4] = '{1, 2, 4, 5};
  int cnt [4] = '{0, 0, 0, 0};
  // quiet pins before the first edge
  initial begin
    tray_present = 4'h0;
    tach = 4'h0;
  end
  // presence follows the plug, tach runs only while fitted
  always @(posedge pclk) begin
    tray_present <= plug;
    for (int i = 0; i < 4; i++) begin
      if (!plug[i]) begin
        tach[i] <= 1'b1;
        cnt[i] <= 0;
      end else if (cnt[i] == HALF[i] - 1) begin
        tach[i] <= ~tach[i];
        cnt[i] <= 0;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule // ftpwm_fan_model

/* tb_fan_tray_pwm_tach_controller.sv */
// self-checking bench for the fan tray pwm and tach controller
`timescale 1ns/1ps
module tb_fan_tray_pwm_tach_controller;
  localparam int WIN = 200;
  localparam int STEP = 50;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, irq, err;
  logic [3:0] plug = 4'h0;
  logic [3:0] tray_present, tach_in, pwm_out;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, seed = 4500;
  int tgt [4];
  int app [4];
  int hi [4];
  // 200 MHz clock and a cycle count for timed reads
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  ftpwm_top #(.TACH_WIN_CYC(WIN), .RAMP_STEP_CYC(STEP)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tray_present(tray_present),
    .tach_in(tach_in), .pwm_out(pwm_out), .irq(irq));
  ftpwm_fan_model fans (.pclk(pclk), .plug(plug),
    .tray_present(tray_present), .tach(tach_in));

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      error_cnt++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] pack(input int v [4]);
    return {8'(v[3]), 8'(v[2]), 8'(v[1]), 8'(v[0])};
  endfunction

  task automatic wait_to(input int t);
    while (cyc < t) @(posedge pclk);
  endtask

  // high cycles per tray over one full pwm period of 63 x 127
  task automatic measure();
    hi = '{0, 0, 0, 0};
    repeat (8001) begin
      @(posedge pclk);
      for (int i = 0; i < 4; i++) hi[i] += (pwm_out[i] === 1'b1);
    end
  endtask

  task automatic note(input int n);
    $display("test %0d finished", n);
  endtask

  // main sequence: reset values, insertion, ramp, duty, tach, removal
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    tgt = '{32, 32, 32, 32};
    app = '{0, 0, 0, 0};
    apb(1'b0, 8'h00, 32'h0); chk(rd, pack(tgt));
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0);
    apb(1'b0, 8'h1C, 32'h0); chk({31'h0, err}, 32'h1);
    note(1);
    apb(1'b1, 8'h18, 32'h0000000F);
    @(posedge pclk);
    plug <= 4'hF;
    t0 = cyc;
    repeat (8) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    apb(1'b0, 8'h10, 32'h0); chk(rd & 32'hFF, 32'h0F);
    apb(1'b1, 8'h14, 32'h000000FF);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    note(2);
    // mid-ramp: ten steps of STEP cycles have passed
    wait_to(t0 + 520);
    app = '{10, 10, 10, 10};
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'hFF);
    wait_to(t0 + 1700);
    app = tgt;
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    apb(1'b0, 8'h0C, 32'h0); chk(rd, 32'h0F);
    note(3);
    tgt = '{63, 0, 1, $random(seed) & 63};
    apb(1'b1, 8'h00, pack(tgt));
    app = tgt;
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    measure();
    foreach (hi[i]) chk(hi[i], app[i] * 127);
    note(4);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, pack('{WIN / 2, WIN / 4, WIN / 8, WIN / 10}));
    note(5);
    @(posedge pclk);
    plug[2] <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, pwm_out[2]}, 32'h0);
    app[2] = 0;
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    apb(1'b0, 8'h10, 32'h0); chk(rd & 32'hFF, 32'h40);
    @(posedge pclk);
    plug[2] <= 1'b1;
    t0 = cyc;
    wait_to(t0 + 30);
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    wait_to(t0 + 80);
    app[2] = 1;
    apb(1'b0, 8'h04, 32'h0); chk(rd, pack(app));
    note(6);
    complete_run();
  end
endmodule // tb_fan_tray_pwm_tach_controller
